// File: logic/token_rearm_decide.v
// Per receive endpoint decision whether to re-arm the IN token request
`timescale 1ns/10ps
`include "usb_mode_regs.vh"

module token_rearm_decide (
  // Clock and reset
  input  wire       clock,
  input  wire       nrst,
  // Settings
  input  wire       host_mode,
  input  wire [1:0] rearm_code,
  input  wire [1:0] framing,
  // Packet read out by the DMA
  input  wire       pkt_done,
  input  wire       pkt_eop,
  input  wire       pkt_short,
  input  wire       count_reached,
  // Request to the core
  output reg        request_set_q
);

  reg eop;
  reg want;

  always @* begin
    // Transparent framing makes every packet an end of packet
    eop = (framing == `FRAMING_TRANSPARENT) | pkt_eop | pkt_short |
          ((framing == `FRAMING_GENERIC_RNDIS) & count_reached);
    case (rearm_code)
      `REARM_BUT_EOP: want = ~eop;
      `REARM_ALWAYS:  want = (framing != `FRAMING_TRANSPARENT);
      default:        want = 1'b0;
    endcase
  end

  always @(posedge clock) begin
    if (!nrst) begin
      request_set_q <= 1'b0;
    end else begin
      request_set_q <= host_mode & pkt_done & want;
    end
  end

endmodule

// File: logic/usb_endpoint_mode_bank.v
// Endpoint framing mode, token rearm and debug halt registers with APB access
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "usb_mode_regs.vh"

// How it works
// - The transmit framing register holds a 2-bit field per endpoint at bits 1-0, 5-4, 9-8, 13-12.
// - Each transmit field selects transparent, RNDIS, CDC or generic RNDIS by code 0 to 3.
// - The receive framing register holds a 2-bit field per endpoint at the same positions.
// - Each receive field uses the same four codes as the transmit fields.
// - The global RNDIS enable forces every endpoint to RNDIS framing whatever its field says.
// - The global RNDIS enable is bit 4 of the module control register.
// - The token rearm register holds a 2-bit field per receive endpoint at bits 1-0 up to 7-6.
// - Rearm code 0 is off, 1 rearms except at end of packet, 3 always rearms, 2 is reserved.
// - With rearm on in host mode, the block asks for the request bit when the DMA clears packet ready.
// - A set request bit makes the core send an IN token for the next packet.
// - In the always setting a request follows every packet the DMA reads out in any framing other than transparent.
// - In the all-but-end setting a request follows only packets not marked end of packet.
// - In the all-but-end setting requests also stop at a short packet or, in generic RNDIS, a reached count.
// - In transparent framing every packet ends a frame, so no request is ever made.
module usb_endpoint_mode_bank #(
  parameter NUM_EP = 4
) (
  // Clock and reset
  input  wire                  clock,
  input  wire                  nrst,
  // APB slave
  input  wire                  psel,
  input  wire                  penable,
  input  wire                  pwrite,
  input  wire [5:0]            paddr,
  input  wire [31:0]           pwdata,
  output wire                  pready,
  output wire                  pslverr,
  output reg  [31:0]           prdata,
  // Effective framing to the core and DMA
  output reg  [2*NUM_EP-1:0]   tx_framing_q,
  output reg  [2*NUM_EP-1:0]   rx_framing_q,
  // Debug halt behaviour
  output wire                  realtime_select,
  output wire                  soft_stop,
  output wire                  ignore_debug_halt,
  // Host receive events from the DMA
  input  wire                  host_mode,
  input  wire [NUM_EP-1:0]     rx_pkt_done,
  input  wire [NUM_EP-1:0]     rx_pkt_eop,
  input  wire [NUM_EP-1:0]     rx_pkt_short,
  input  wire [NUM_EP-1:0]     rx_count_reached,
  // Request bit set strobes to the core
  output wire [NUM_EP-1:0]     request_packet_bit_set
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  reg         global_rndis_q;
  reg  [2:0]  debug_halt_q;
  reg  [15:0] tx_select_q;
  reg  [15:0] rx_select_q;
  reg  [15:0] rearm_q;

  wire        setup_phase;
  wire        wr_access;
  reg         mapped;
  reg  [31:0] rd_value;
  wire [15:0] effective_mode;
  wire [2*NUM_EP-1:0] tx_eff_all;
  wire [2*NUM_EP-1:0] rx_eff_all;

  assign setup_phase = psel & ~penable;
  assign wr_access   = psel & penable & pwrite & mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  always @* begin
    mapped   = 1'b1;
    rd_value = 32'h0000_0000;
    case (paddr)
      `OFS_MODULE_CTL: begin
        rd_value[`CTL_GLOBAL_RNDIS_BIT] = global_rndis_q;
      end
      `OFS_DEBUG_HALT: begin
        rd_value[2:0] = debug_halt_q;
      end
      `OFS_TX_FRAMING: begin
        rd_value[15:0] = tx_select_q;
      end
      `OFS_RX_FRAMING: begin
        rd_value[15:0] = rx_select_q;
      end
      `OFS_TOKEN_REARM: begin
        rd_value[15:0] = rearm_q;
      end
      `OFS_EFFECTIVE_MODE: begin
        rd_value[15:0] = effective_mode;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Zero wait states; read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always @(posedge clock) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  always @(posedge clock) begin
    if (!nrst) begin
      global_rndis_q <= `CTL_RESET_VAL;
      debug_halt_q   <= `DBG_RESET_VAL;
      tx_select_q    <= 16'h0000;
      rx_select_q    <= 16'h0000;
      rearm_q        <= 16'h0000;
    end else if (wr_access) begin
      case (paddr)
        `OFS_MODULE_CTL: begin
          global_rndis_q <= pwdata[`CTL_GLOBAL_RNDIS_BIT];
        end
        `OFS_DEBUG_HALT: begin
          debug_halt_q <= pwdata[2:0];
        end
        `OFS_TX_FRAMING: begin
          tx_select_q <= pwdata[15:0] & `FRAMING_WRITE_MASK;
        end
        `OFS_RX_FRAMING: begin
          rx_select_q <= pwdata[15:0] & `FRAMING_WRITE_MASK;
        end
        `OFS_TOKEN_REARM: begin
          rearm_q <= pwdata[15:0] & `REARM_WRITE_MASK;
        end
        default: begin
          global_rndis_q <= global_rndis_q;
        end
      endcase
    end
  end

  assign ignore_debug_halt = debug_halt_q[`DBG_IGNORE_HALT_BIT];
  assign soft_stop         = debug_halt_q[`DBG_SOFT_STOP_BIT];
  assign realtime_select   = debug_halt_q[`DBG_REALTIME_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Per endpoint framing and token rearm

  genvar ep;
  generate
    for (ep = 0; ep < NUM_EP; ep = ep + 1) begin : g_ep
      wire [1:0] tx_field;
      wire [1:0] rx_field;
      wire [1:0] tx_eff;
      wire [1:0] rx_eff;

      assign tx_field = tx_select_q[`FRAMING_STRIDE*ep +: 2];
      assign rx_field = rx_select_q[`FRAMING_STRIDE*ep +: 2];
      assign tx_eff   = global_rndis_q ? `FRAMING_RNDIS : tx_field;
      assign rx_eff   = global_rndis_q ? `FRAMING_RNDIS : rx_field;

      assign effective_mode[2*ep +: 2]          = tx_eff;
      assign effective_mode[2*NUM_EP+2*ep +: 2] = rx_eff;

      assign tx_eff_all[2*ep +: 2] = tx_eff;
      assign rx_eff_all[2*ep +: 2] = rx_eff;

      // Strobe feeds the core, which turns the set bit into an IN token
      token_rearm_decide u_decide (
        .clock         (clock),
        .nrst          (nrst),
        .host_mode     (host_mode),
        .rearm_code    (rearm_q[`REARM_STRIDE*ep +: 2]),
        .framing       (rx_eff),
        .pkt_done      (rx_pkt_done[ep]),
        .pkt_eop       (rx_pkt_eop[ep]),
        .pkt_short     (rx_pkt_short[ep]),
        .count_reached (rx_count_reached[ep]),
        .request_set_q (request_packet_bit_set[ep])
      );
    end
  endgenerate

  // One process drives both output vectors, keeping a single driver on each
  always @(posedge clock) begin
    if (!nrst) begin
      tx_framing_q <= {NUM_EP{`FRAMING_RESET_VAL}};
      rx_framing_q <= {NUM_EP{`FRAMING_RESET_VAL}};
    end else begin
      tx_framing_q <= tx_eff_all;
      rx_framing_q <= rx_eff_all;
    end
  end

endmodule

// File: logic/usb_mode_regs.vh
// Register offsets, field layouts and codes for the endpoint mode bank
`ifndef USB_MODE_REGS_VH
`define USB_MODE_REGS_VH

// Byte offsets on the register bus
`define OFS_MODULE_CTL      6'h00
`define OFS_DEBUG_HALT      6'h04
`define OFS_TX_FRAMING      6'h08
`define OFS_RX_FRAMING      6'h0c
`define OFS_TOKEN_REARM     6'h10
`define OFS_EFFECTIVE_MODE  6'h14

// Module control register
`define CTL_GLOBAL_RNDIS_BIT  4
`define CTL_RESET_VAL         1'b0

// Debug halt behaviour register
`define DBG_IGNORE_HALT_BIT   0
`define DBG_SOFT_STOP_BIT     1
`define DBG_REALTIME_BIT      2
`define DBG_RESET_VAL         3'h3

// Framing fields: two bits per endpoint, four bits apart
`define FRAMING_STRIDE        4
`define FRAMING_RESET_VAL     2'h0
`define FRAMING_WRITE_MASK    16'h3333

// Token rearm fields: two bits per endpoint, packed
`define REARM_STRIDE          2
`define REARM_RESET_VAL       2'h0
`define REARM_WRITE_MASK      16'h00ff

// Framing codes
`define FRAMING_TRANSPARENT   2'h0
`define FRAMING_RNDIS         2'h1
`define FRAMING_CDC           2'h2
`define FRAMING_GENERIC_RNDIS 2'h3

// Token rearm codes
`define REARM_OFF             2'h0
`define REARM_BUT_EOP         2'h1
`define REARM_RESERVED        2'h2
`define REARM_ALWAYS          2'h3

`endif

// File: testbench/dma_event_model.sv
// Behavioural DMA source of receive packet events
`timescale 1ns/10ps
module dma_event_model (
  // Clock
  input wire         clock,
  // Events to the bank
  output logic       host_mode = 1'b1,
  output logic [3:0] rx_pkt_done = 4'h0,
  output logic [3:0] rx_pkt_eop = 4'h0,
  output logic [3:0] rx_pkt_short = 4'h0,
  output logic [3:0] rx_count_reached = 4'h0
);
  ////////////////
  // Qualifiers invert after the pulse so stale values never look valid
  task send(input int ep, input e, input s, input c);
    @(posedge clock);
    rx_pkt_done <= 4'h1 << ep;
    rx_pkt_eop <= {4{e}};
    rx_pkt_short <= {4{s}};
    rx_count_reached <= {4{c}};
    @(posedge clock);
    rx_pkt_done <= 4'h0;
    rx_pkt_eop <= {4{~e}};
    rx_pkt_short <= {4{~s}};
    rx_count_reached <= {4{~c}};
  endtask
endmodule

// File: testbench/mode_bank_assertions.sv
// Port checker for the endpoint mode bank
`timescale 1ns/10ps
module mode_bank_assertions #(
  parameter NUM_EP = 4
) (
  // Clock and reset
  input wire                clock,
  input wire                nrst,
  // Bus and outputs
  input wire                pwrite,
  input wire                psel,
  input wire                penable,
  input wire                pready,
  input wire                pslverr,
  input wire [31:0]         prdata,
  input wire [2*NUM_EP-1:0] tx_framing_q,
  input wire [2*NUM_EP-1:0] rx_framing_q,
  input wire                realtime_select,
  input wire                soft_stop,
  input wire                ignore_debug_halt,
  input wire                host_mode,
  input wire [NUM_EP-1:0]   rx_pkt_done,
  input wire [NUM_EP-1:0]   request_packet_bit_set
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  ////////////////
  ready_high_a: assert property (pready)
    else $error("pready low");
  error_in_access_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  unmapped_read_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  request_cause_a: assert property (
    (request_packet_bit_set & ~$past(rx_pkt_done)) == 0)
    else $error("request without packet");
  host_only_a: assert property (
    !host_mode && rx_pkt_done != 0 |=> request_packet_bit_set == 0)
    else $error("request outside host");
  transparent_quiet_a: assert property (
    rx_pkt_done[3] && rx_framing_q[7:6] == 2'h0 |=> !request_packet_bit_set[3])
    else $error("request in transparent");
  framing_reset_a: assert property (
    $rose(nrst) |-> tx_framing_q == 0 && rx_framing_q == 0)
    else $error("framing reset wrong");
  debug_reset_a: assert property (
    $rose(nrst) |-> soft_stop && ignore_debug_halt && !realtime_select)
    else $error("debug reset wrong");
  framing_lag_a: assert property (
    $changed({tx_framing_q, rx_framing_q}) |-> $past(psel && penable && pwrite, 2))
    else $error("framing changed without write");
  cover property (request_packet_bit_set != 0);
  cover property (pslverr);
  cover property (tx_framing_q == 8'h55);
endmodule
bind usb_endpoint_mode_bank mode_bank_assertions #(.NUM_EP(NUM_EP)) chk (
  .clock                  (clock),
  .nrst                   (nrst),
  .pwrite                 (pwrite),
  .psel                   (psel),
  .penable                (penable),
  .pready                 (pready),
  .pslverr                (pslverr),
  .prdata                 (prdata),
  .tx_framing_q           (tx_framing_q),
  .rx_framing_q           (rx_framing_q),
  .realtime_select        (realtime_select),
  .soft_stop              (soft_stop),
  .ignore_debug_halt      (ignore_debug_halt),
  .host_mode              (host_mode),
  .rx_pkt_done            (rx_pkt_done),
  .request_packet_bit_set (request_packet_bit_set)
);

// File: testbench/usb_endpoint_mode_rx_token_rearm_ctl_regs_bench.sv
// Self-checking bench for the endpoint mode bank
`timescale 1ns/10ps
module usb_endpoint_mode_rx_token_rearm_ctl_regs_bench;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [5:0]  paddr = 6'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;
  logic        er;
  wire         pready, pslverr, realtime_select, soft_stop, ignore_debug_halt, host_mode;
  wire [31:0]  prdata;
  wire [7:0]   tx_framing_q, rx_framing_q;
  wire [3:0]   rx_pkt_done, rx_pkt_eop, rx_pkt_short, rx_count_reached;
  wire [3:0]   request_packet_bit_set;
  int          miscompares = 0;
  int          n_compared = 0;
  always #4 clock = ~clock;
  usb_endpoint_mode_bank uut (
    .clock                  (clock),
    .nrst                   (nrst),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .prdata                 (prdata),
    .tx_framing_q           (tx_framing_q),
    .rx_framing_q           (rx_framing_q),
    .realtime_select        (realtime_select),
    .soft_stop              (soft_stop),
    .ignore_debug_halt      (ignore_debug_halt),
    .host_mode              (host_mode),
    .rx_pkt_done            (rx_pkt_done),
    .rx_pkt_eop             (rx_pkt_eop),
    .rx_pkt_short           (rx_pkt_short),
    .rx_count_reached       (rx_count_reached),
    .request_packet_bit_set (request_packet_bit_set)
  );
  dma_event_model dma (
    .clock            (clock),
    .host_mode        (host_mode),
    .rx_pkt_done      (rx_pkt_done),
    .rx_pkt_eop       (rx_pkt_eop),
    .rx_pkt_short     (rx_pkt_short),
    .rx_count_reached (rx_count_reached)
  );
  ////////////////
  task chk(input [31:0] got, input [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task xfer(input w, input [5:0] a, input [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input [5:0] a, input [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task rq(input int ep, input e, input s, input c, input x);
    dma.send(ep, e, s, c);
    @(posedge clock);
    chk(request_packet_bit_set, {31'h0, x} << ep);
    @(posedge clock);
    chk(request_packet_bit_set, 32'h0);
  endtask
  task settle;
    repeat (2) @(posedge clock);
  endtask
  ////////////////
  task t_reset;
    rdchk(6'h00, 32'h0);
    rdchk(6'h04, 32'h3);
    chk({realtime_select, soft_stop, ignore_debug_halt}, 3'h3);
    rdchk(6'h08, 32'h0);
    rdchk(6'h0c, 32'h0);
    rdchk(6'h10, 32'h0);
  endtask
  task t_fields;
    logic [1:0] k;
    for (int i = 0; i < 4; i++) begin
      k = 2'(i);
      xfer(1'b1, 6'h08, {16'hffff, {4{2'h3, k}}});
      xfer(1'b1, 6'h0c, {16'hffff, {4{2'h3, k}}});
      settle;
      chk(tx_framing_q, {4{k}});
      chk(rx_framing_q, {4{k}});
      rdchk(6'h0c, {16'h0, {4{2'h0, k}}});
    end
    xfer(1'b1, 6'h10, 32'hffffffff);
    rdchk(6'h10, 32'hff);
  endtask
  task t_debug;
    xfer(1'b1, 6'h04, 32'hfffffffc);
    settle;
    chk({realtime_select, soft_stop, ignore_debug_halt}, 3'h4);
    rdchk(6'h04, 32'h4);
    chk(er, 1'b0);
  endtask
  task t_rearm;
    xfer(1'b1, 6'h08, 32'h0123);
    xfer(1'b1, 6'h0c, 32'h0213);
    xfer(1'b1, 6'h10, 32'hed);
    settle;
    chk(tx_framing_q, 8'h1b);
    chk(rx_framing_q, 8'h27);
    rq(0, 0, 0, 0, 1);
    rq(0, 0, 0, 1, 0);
    rq(0, 0, 1, 0, 0);
    rq(0, 1, 0, 0, 0);
    rq(1, 0, 1, 0, 1);
    rq(2, 0, 0, 0, 0);
    rq(3, 0, 0, 0, 0);
    dma.host_mode <= 1'b0;
    rq(1, 0, 0, 0, 0);
    dma.host_mode <= 1'b1;
  endtask
  task t_global;
    xfer(1'b1, 6'h00, 32'hffffffff);
    settle;
    chk(tx_framing_q, 8'h55);
    chk(rx_framing_q, 8'h55);
    rdchk(6'h00, 32'h10);
    rdchk(6'h14, 32'h5555);
    rq(3, 0, 0, 0, 1);
    xfer(1'b1, 6'h00, 32'h0);
    settle;
    chk(tx_framing_q, 8'h1b);
    rdchk(6'h14, 32'h271b);
    xfer(1'b1, 6'h14, 32'hffffffff);
    chk(er, 1'b0);
    rdchk(6'h14, 32'h271b);
    xfer(1'b1, 6'h10, 32'h0);
    rq(1, 0, 0, 0, 0);
    rq(0, 0, 0, 0, 0);
  endtask
  task t_unmapped;
    xfer(1'b0, 6'h18, 32'h0);
    chk(rd, 32'h0);
    chk(er, 1'b1);
    xfer(1'b1, 6'h18, 32'hffffffff);
    chk(er, 1'b1);
    rdchk(6'h00, 32'h0);
  endtask
  ////////////////
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    t_reset;
    t_fields;
    t_debug;
    t_rearm;
    t_global;
    t_unmapped;
    summarize;
  end
  initial begin
    repeat (5000) @(posedge clock);
    miscompares++;
    summarize;
  end
endmodule
